//--- hdl/cpsc_top.sv
`timescale 1ns/10ps
`include "cpsc_params.svh"

module cpsc_top import cpsc_pkg::*; #(
  parameter int unsigned DL_CYCLES     = `CPSC_DL_TYP_CYC,
  parameter int unsigned DL_MAX_CYCLES = `CPSC_DL_MAX_CYC
) (
  // Clock, reset, enable
  input  wire logic             ref_clk_i,
  input  wire logic             reset_i,
  input  wire logic             ce_i,
  // Control pins
  input  wire logic             program_request_n_i,
  input  wire logic             sleep_request_n_i,
  input  wire logic             io_output_enable_n_i,
  input  wire logic [1:0]       config_mode_i,
  // Open-drain status pins
  input  wire logic             init_ready_n_i,
  output logic                  init_ready_n_o,
  output logic                  init_ready_n_oe_o,
  output logic                  done_o,
  output logic                  done_oe_o,
  // Configuration link
  input  wire logic             config_clock_i,
  input  wire cpsc_cfg_pins_t   cfg_pins_i,
  output logic                  serial_out_o,
  output logic                  serial_out_oe_o,
  // Test access port
  input  wire logic             tck_i,
  input  wire logic             tms_i,
  input  wire logic             tdi_i,
  output logic                  tdo_o,
  output logic                  tdo_oe_o,
  // Fabric control and status
  output cpsc_fabric_ctl_t      fabric_ctl_o,
  output cpsc_port_t            config_port_o
);
  localparam logic [18:0] DL_END = 19'(DL_CYCLES);
  localparam logic [18:0] DL_MAX = 19'(DL_MAX_CYCLES);
  localparam int          SLP_N  = 20;
  localparam logic [`CPSC_SYNC_W-1:0] SY_RST = `CPSC_SYNC_RST;

  // Pin synchronisers
  logic [`CPSC_SYNC_W-1:0] sy_in;
  logic [`CPSC_SYNC_W-1:0] sy_s1_reg;
  logic [`CPSC_SYNC_W-1:0] sy_s2_reg;
  assign sy_in = {tdi_i, tms_i, tck_i, init_ready_n_i, config_mode_i,
                  io_output_enable_n_i, sleep_request_n_i, program_request_n_i};
  for (genvar g = 0; g < `CPSC_SYNC_W; g++) begin : g_sync
    always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
        sy_s1_reg[g] <= SY_RST[g];
        sy_s2_reg[g] <= SY_RST[g];
      end else if (ce_i) begin
        sy_s1_reg[g] <= sy_in[g];
        sy_s2_reg[g] <= sy_s1_reg[g];
      end
    end
  end

  logic       prog_n_s;
  logic       sleep_n_s;
  logic       toe_n_s;
  logic [1:0] mode_s;
  logic       tms_s;
  logic       tdi_s;
  assign prog_n_s  = sy_s2_reg[`CPSC_SY_PROG];
  assign sleep_n_s = sy_s2_reg[`CPSC_SY_SLEEP];
  assign toe_n_s   = sy_s2_reg[`CPSC_SY_TOE];
  assign mode_s    = {sy_s2_reg[`CPSC_SY_MODE1], sy_s2_reg[`CPSC_SY_MODE0]};
  assign tms_s     = sy_s2_reg[`CPSC_SY_TMS];
  assign tdi_s     = sy_s2_reg[`CPSC_SY_TDI];

  // Edge detectors and link-done level crossing
  logic init_d_reg;
  logic tck_d_reg;
  logic ldt_s1_reg;
  logic ldt_s2_reg;
  logic ldt_s3_reg;
  logic link_done_tgl_reg;
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      init_d_reg <= 1'b0;
      tck_d_reg  <= 1'b0;
      ldt_s1_reg <= 1'b0;
      ldt_s2_reg <= 1'b0;
      ldt_s3_reg <= 1'b0;
    end else if (ce_i) begin
      init_d_reg <= sy_s2_reg[`CPSC_SY_INIT];
      tck_d_reg  <= sy_s2_reg[`CPSC_SY_TCK];
      ldt_s1_reg <= link_done_tgl_reg;
      ldt_s2_reg <= ldt_s1_reg;
      ldt_s3_reg <= ldt_s2_reg;
    end
  end
  logic init_rise;
  logic tck_rise;
  logic tck_fall;
  logic link_done;
  assign init_rise = sy_s2_reg[`CPSC_SY_INIT] & ~init_d_reg;
  assign tck_rise  = sy_s2_reg[`CPSC_SY_TCK] & ~tck_d_reg;
  assign tck_fall  = ~sy_s2_reg[`CPSC_SY_TCK] & tck_d_reg;
  assign link_done = ldt_s2_reg & ldt_s3_reg;

  // Test access port, sampled on the system clock
  cpsc_tap_t   tap_reg, tap_next;
  logic [7:0]  ir_sh_reg, ir_sh_next;
  logic [7:0]  ir_reg, ir_next;
  logic        dr_reg, dr_next;
  logic [6:0]  jcnt_reg, jcnt_next;
  logic        tdo_reg, tdo_next;
  logic        tdo_oe_reg, tdo_oe_next;
  logic        jtag_en_evt;
  cpsc_state_t state_reg, state_next;
  cpsc_port_t  port_reg, port_next;

  assign jtag_en_evt = tck_rise && (tap_reg == CPSC_TAP_UPDIR) && (ir_sh_reg == `CPSC_IR_CFG_EN);

  always_comb begin
    tap_next    = tap_reg;
    ir_sh_next  = ir_sh_reg;
    ir_next     = ir_reg;
    dr_next     = dr_reg;
    jcnt_next   = (state_reg == CPSC_ST_LOAD) ? jcnt_reg : 7'h00;
    tdo_next    = tdo_reg;
    tdo_oe_next = tdo_oe_reg;
    if (tck_rise) begin
      case (tap_reg)
        CPSC_TAP_TLR:   begin tap_next = tms_s ? CPSC_TAP_TLR : CPSC_TAP_RTI; ir_next = `CPSC_IR_BYPASS; end
        CPSC_TAP_RTI:   tap_next = tms_s ? CPSC_TAP_SELDR : CPSC_TAP_RTI;
        CPSC_TAP_SELDR: tap_next = tms_s ? CPSC_TAP_SELIR : CPSC_TAP_CAPDR;
        CPSC_TAP_CAPDR: tap_next = tms_s ? CPSC_TAP_EX1DR : CPSC_TAP_SHDR;
        CPSC_TAP_SHDR: begin
          tap_next = tms_s ? CPSC_TAP_EX1DR : CPSC_TAP_SHDR;
          dr_next  = tdi_s;
          if (ir_reg == `CPSC_IR_CFG_EN && port_reg == CPSC_PORT_JTAG
              && state_reg == CPSC_ST_LOAD) begin
            jcnt_next = jcnt_reg + 7'h01;
          end
        end
        CPSC_TAP_EX1DR: tap_next = tms_s ? CPSC_TAP_UPDDR : CPSC_TAP_PAUDR;
        CPSC_TAP_PAUDR: tap_next = tms_s ? CPSC_TAP_EX2DR : CPSC_TAP_PAUDR;
        CPSC_TAP_EX2DR: tap_next = tms_s ? CPSC_TAP_UPDDR : CPSC_TAP_SHDR;
        CPSC_TAP_UPDDR: tap_next = tms_s ? CPSC_TAP_SELDR : CPSC_TAP_RTI;
        CPSC_TAP_SELIR: tap_next = tms_s ? CPSC_TAP_TLR : CPSC_TAP_CAPIR;
        CPSC_TAP_CAPIR: begin tap_next = tms_s ? CPSC_TAP_EX1IR : CPSC_TAP_SHIR; ir_sh_next = `CPSC_IR_CAPTURE; end
        CPSC_TAP_SHIR:  begin tap_next = tms_s ? CPSC_TAP_EX1IR : CPSC_TAP_SHIR; ir_sh_next = {tdi_s, ir_sh_reg[7:1]}; end
        CPSC_TAP_EX1IR: tap_next = tms_s ? CPSC_TAP_UPDIR : CPSC_TAP_PAUIR;
        CPSC_TAP_PAUIR: tap_next = tms_s ? CPSC_TAP_EX2IR : CPSC_TAP_PAUIR;
        CPSC_TAP_EX2IR: tap_next = tms_s ? CPSC_TAP_UPDIR : CPSC_TAP_SHIR;
        CPSC_TAP_UPDIR: begin tap_next = tms_s ? CPSC_TAP_SELDR : CPSC_TAP_RTI; ir_next = ir_sh_reg; end
        default:        tap_next = CPSC_TAP_TLR;
      endcase
    end
    if (tck_fall) begin
      tdo_next    = (tap_reg == CPSC_TAP_SHIR) ? ir_sh_reg[0] : dr_reg;
      tdo_oe_next = (tap_reg == CPSC_TAP_SHIR) || (tap_reg == CPSC_TAP_SHDR);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      tap_reg    <= CPSC_TAP_TLR;
      ir_sh_reg  <= 8'h00;
      ir_reg     <= `CPSC_IR_BYPASS;
      dr_reg     <= 1'b0;
      jcnt_reg   <= 7'h00;
      tdo_reg    <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end else if (ce_i) begin
      tap_reg    <= tap_next;
      ir_sh_reg  <= ir_sh_next;
      ir_reg     <= ir_next;
      dr_reg     <= dr_next;
      jcnt_reg   <= jcnt_next;
      tdo_reg    <= tdo_next;
      tdo_oe_reg <= tdo_oe_next;
    end
  end

  // Configuration and sleep sequencer
  logic [1:0]       mode_reg, mode_next;
  logic [4:0]       clr_cnt_reg, clr_cnt_next;
  logic [4:0]       slp_cnt_reg, slp_cnt_next;
  logic [18:0]      dl_cnt_reg, dl_cnt_next;
  logic             load_link_reg, load_link_next;
  logic             init_oe_reg, init_oe_next;
  cpsc_fabric_ctl_t ctl_reg, ctl_next;

  always_comb begin
    state_next     = state_reg;
    port_next      = port_reg;
    mode_next      = mode_reg;
    load_link_next = load_link_reg;
    clr_cnt_next   = 5'h00;
    slp_cnt_next   = sleep_n_s ? 5'h00 : slp_cnt_reg;
    if (!sleep_n_s && slp_cnt_reg != `CPSC_SLEEP_CYC) begin
      slp_cnt_next = slp_cnt_reg + 5'h01;
    end
    dl_cnt_next = prog_n_s ? dl_cnt_reg : 19'h00000;
    if (prog_n_s && dl_cnt_reg != DL_MAX) begin
      dl_cnt_next = dl_cnt_reg + 19'h00001;
    end
    case (state_reg)
      CPSC_ST_CLEAR: begin
        load_link_next = 1'b0;
        if (clr_cnt_reg != `CPSC_CLEAR_CYC) begin
          clr_cnt_next = clr_cnt_reg + 5'h01;
        end else if (prog_n_s) begin
          state_next = CPSC_ST_WAIT;
        end
      end
      CPSC_ST_WAIT: begin
        if (init_rise && port_reg != CPSC_PORT_JTAG) begin
          mode_next      = mode_s;
          port_next      = CPSC_PORT_SYSCFG;
          state_next     = CPSC_ST_LOAD;
          load_link_next = (mode_s != `CPSC_MODE_SDM);
        end else if (jtag_en_evt && port_reg != CPSC_PORT_SYSCFG) begin
          port_next  = CPSC_PORT_JTAG;
          state_next = CPSC_ST_LOAD;
        end
      end
      CPSC_ST_LOAD: begin
        if (port_reg == CPSC_PORT_JTAG ? (jcnt_reg >= `CPSC_CFG_BITS)
            : (mode_reg == `CPSC_MODE_SDM ? (dl_cnt_reg >= DL_END) : link_done)) begin
          state_next     = CPSC_ST_USER;
          load_link_next = 1'b0;
        end
      end
      CPSC_ST_USER: state_next = CPSC_ST_USER;
      CPSC_ST_SLEEP: begin
        if (sleep_n_s) begin
          state_next = CPSC_ST_CLEAR;
        end
      end
      default: state_next = CPSC_ST_CLEAR;
    endcase
    if (!prog_n_s && port_reg != CPSC_PORT_JTAG && state_reg != CPSC_ST_SLEEP) begin
      state_next     = CPSC_ST_CLEAR;
      load_link_next = 1'b0;
    end
    if (slp_cnt_reg == `CPSC_SLEEP_CYC && state_reg != CPSC_ST_SLEEP) begin
      state_next     = CPSC_ST_SLEEP;
      load_link_next = 1'b0;
    end
    init_oe_next = (state_next == CPSC_ST_CLEAR)
                 || (state_next == CPSC_ST_LOAD && port_next == CPSC_PORT_SYSCFG
                     && mode_next == `CPSC_MODE_SDM);
    ctl_next.fabric_run   = (state_next == CPSC_ST_USER);
    ctl_next.fabric_clear = (state_next == CPSC_ST_CLEAR);
    ctl_next.io_tristate  = (state_next != CPSC_ST_USER) || !toe_n_s;
    ctl_next.user_io_mode = (state_next == CPSC_ST_USER);
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_reg     <= CPSC_ST_CLEAR;
      port_reg      <= CPSC_PORT_NONE;
      mode_reg      <= `CPSC_MODE_SERIAL;
      clr_cnt_reg   <= 5'h00;
      slp_cnt_reg   <= 5'h00;
      dl_cnt_reg    <= 19'h00000;
      load_link_reg <= 1'b0;
      init_oe_reg   <= 1'b1;
      ctl_reg       <= 4'h6;
    end else if (ce_i) begin
      state_reg     <= state_next;
      port_reg      <= port_next;
      mode_reg      <= mode_next;
      clr_cnt_reg   <= clr_cnt_next;
      slp_cnt_reg   <= slp_cnt_next;
      dl_cnt_reg    <= dl_cnt_next;
      load_link_reg <= load_link_next;
      init_oe_reg   <= init_oe_next;
      ctl_reg       <= ctl_next;
    end
  end

  // Link domain on the configuration clock
  logic       ld_en_s1_reg;
  logic       ld_en_s2_reg;
  logic [6:0] bit_cnt_reg, bit_cnt_next;
  logic       sout_reg, sout_next;
  logic       sout_oe_reg, sout_oe_next;
  logic       link_done_tgl_next;

  always_ff @(posedge config_clock_i) begin
    ld_en_s1_reg <= load_link_reg;
    ld_en_s2_reg <= ld_en_s1_reg;
  end

  always_comb begin
    bit_cnt_next       = 7'h00;
    sout_next          = sout_reg;
    sout_oe_next       = ld_en_s2_reg;
    link_done_tgl_next = 1'b0;
    if (ld_en_s2_reg) begin
      bit_cnt_next       = bit_cnt_reg;
      link_done_tgl_next = link_done_tgl_reg;
      if (mode_reg == `CPSC_MODE_PARALLEL) begin
        if (!cfg_pins_i.select_a_n && !cfg_pins_i.select_b_n
            && !cfg_pins_i.write_strobe_n) begin
          bit_cnt_next = bit_cnt_reg + `CPSC_BYTE_BITS;
        end
      end else begin
        bit_cnt_next = bit_cnt_reg + 7'h01;
        sout_next    = cfg_pins_i.serial_in;
      end
      if (bit_cnt_reg < `CPSC_CFG_BITS && bit_cnt_next >= `CPSC_CFG_BITS) begin
        link_done_tgl_next = 1'b1;
      end
    end
  end

  always_ff @(posedge config_clock_i) begin
    bit_cnt_reg       <= bit_cnt_next;
    sout_reg          <= sout_next;
    sout_oe_reg       <= sout_oe_next;
    link_done_tgl_reg <= link_done_tgl_next;
  end

  // Outputs
  assign init_ready_n_o    = 1'b0;
  assign init_ready_n_oe_o = init_oe_reg;
  assign done_o            = 1'b0;
  assign done_oe_o         = ~ctl_reg.user_io_mode;
  assign serial_out_o      = sout_reg;
  assign serial_out_oe_o   = sout_oe_reg;
  assign tdo_o             = tdo_reg;
  assign tdo_oe_o          = tdo_oe_reg;
  assign fabric_ctl_o      = ctl_reg;
  assign config_port_o     = port_reg;

  // Checks
  a_sleep_entry: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ce_i && $rose(state_reg == CPSC_ST_SLEEP) |-> $past(slp_cnt_reg) == SLP_N[4:0])
    else $error("sleep entered without full delay");
  a_sleep_dark: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ce_i && state_reg == CPSC_ST_SLEEP |=> fabric_ctl_o.io_tristate && !fabric_ctl_o.fabric_run)
    else $error("sleep left fabric running");
  a_prog_clear: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ce_i && !prog_n_s && port_reg != CPSC_PORT_JTAG && state_reg != CPSC_ST_SLEEP
    && slp_cnt_reg != SLP_N[4:0] |=> state_reg == CPSC_ST_CLEAR && init_ready_n_oe_o)
    else $error("program request did not clear");
  a_mode_capture: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ce_i && $changed(mode_reg) |-> $past(init_rise) && mode_reg == $past(mode_s))
    else $error("mode captured off the init rise");
  a_sdm_init_low: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    state_reg == CPSC_ST_LOAD && port_reg == CPSC_PORT_SYSCFG
    && mode_reg == `CPSC_MODE_SDM |-> init_ready_n_oe_o)
    else $error("init released in self-download");
  a_done_release: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    state_reg == CPSC_ST_USER |-> !done_oe_o && fabric_ctl_o.user_io_mode)
    else $error("done not released with user mode");
  a_download_bound: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ce_i && dl_cnt_reg == DL_MAX && mode_reg == `CPSC_MODE_SDM && state_reg == CPSC_ST_LOAD
    && port_reg == CPSC_PORT_SYSCFG |-> 1'b0)
    else $error("self-download overran its time");
  a_port_lock: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    port_reg != CPSC_PORT_NONE |=> port_reg == $past(port_reg))
    else $error("configuration port lock changed");
  a_jtag_enable: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    $rose(port_reg == CPSC_PORT_JTAG) |-> $past(jtag_en_evt))
    else $error("test port took over without instruction");
  a_serial_out: assert property (@(posedge config_clock_i) disable iff (!ld_en_s2_reg)
    mode_reg != `CPSC_MODE_PARALLEL && $past(ld_en_s2_reg)
    |-> serial_out_o == $past(cfg_pins_i.serial_in))
    else $error("serial out not following serial in");
  a_toe_tristate: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ce_i && !toe_n_s |=> fabric_ctl_o.io_tristate)
    else $error("output enable low left I/O driven");
  a_tdo_falling: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    $changed(tdo_oe_o) || $changed(tdo_o) |-> $past(tck_fall))
    else $error("test data out moved off falling edge");
  c_sdm_done: cover property (@(posedge ref_clk_i) disable iff (reset_i)
    mode_reg == `CPSC_MODE_SDM && $rose(state_reg == CPSC_ST_USER));
  c_sleep_wake: cover property (@(posedge ref_clk_i) disable iff (reset_i)
    state_reg == CPSC_ST_SLEEP ##1 state_reg == CPSC_ST_CLEAR);
  c_jtag_lock: cover property (@(posedge ref_clk_i) disable iff (reset_i)
    $rose(port_reg == CPSC_PORT_JTAG));
  c_link_done: cover property (@(posedge ref_clk_i) disable iff (reset_i)
    link_done && state_reg == CPSC_ST_LOAD);
endmodule

//--- hdl/cpsc_params.svh
`ifndef CPSC_PARAMS_SVH
`define CPSC_PARAMS_SVH
// Clock and timing
`define CPSC_CLK_PERIOD_NS  5
`define CPSC_DL_TYP_US      1400
`define CPSC_DL_MAX_US      2000
`define CPSC_DL_TYP_CYC     ((`CPSC_DL_TYP_US * 1000) / `CPSC_CLK_PERIOD_NS)
`define CPSC_DL_MAX_CYC     ((`CPSC_DL_MAX_US * 1000) / `CPSC_CLK_PERIOD_NS)
`define CPSC_SLEEP_DELAY_NS 100
`define CPSC_SLEEP_CYC      5'((`CPSC_SLEEP_DELAY_NS + `CPSC_CLK_PERIOD_NS - 1) / `CPSC_CLK_PERIOD_NS)
`define CPSC_CLEAR_CYC      5'h10
// Bitstream size
`define CPSC_CFG_BITS       7'h40
`define CPSC_BYTE_BITS      7'h08
// Test access port instructions
`define CPSC_IR_CFG_EN      8'h3A
`define CPSC_IR_BYPASS      8'hFF
`define CPSC_IR_CAPTURE     8'h01
// Captured mode encodings
`define CPSC_MODE_SERIAL    2'h0
`define CPSC_MODE_PARALLEL  2'h1
`define CPSC_MODE_SDM       2'h3
// Synchroniser bit positions and reset image
`define CPSC_SY_PROG        0
`define CPSC_SY_SLEEP       1
`define CPSC_SY_TOE         2
`define CPSC_SY_MODE0       3
`define CPSC_SY_MODE1       4
`define CPSC_SY_INIT        5
`define CPSC_SY_TCK         6
`define CPSC_SY_TMS         7
`define CPSC_SY_TDI         8
`define CPSC_SYNC_W         9
`define CPSC_SYNC_RST       9'h187
`endif

//--- hdl/cpsc_pkg.sv
package cpsc_pkg;
  typedef enum logic [2:0] {
    CPSC_ST_CLEAR = 3'h0,
    CPSC_ST_WAIT  = 3'h1,
    CPSC_ST_LOAD  = 3'h3,
    CPSC_ST_USER  = 3'h2,
    CPSC_ST_SLEEP = 3'h6
  } cpsc_state_t;

  typedef enum logic [1:0] {
    CPSC_PORT_NONE   = 2'h0,
    CPSC_PORT_SYSCFG = 2'h1,
    CPSC_PORT_JTAG   = 2'h3
  } cpsc_port_t;

  typedef enum logic [3:0] {
    CPSC_TAP_TLR = 4'h0, CPSC_TAP_RTI = 4'h1, CPSC_TAP_SELDR = 4'h3, CPSC_TAP_CAPDR = 4'h2,
    CPSC_TAP_SHDR = 4'h6, CPSC_TAP_EX1DR = 4'h7, CPSC_TAP_PAUDR = 4'h5, CPSC_TAP_EX2DR = 4'h4,
    CPSC_TAP_UPDDR = 4'hC, CPSC_TAP_SELIR = 4'hD, CPSC_TAP_CAPIR = 4'hF, CPSC_TAP_SHIR = 4'hE,
    CPSC_TAP_EX1IR = 4'hA, CPSC_TAP_PAUIR = 4'hB, CPSC_TAP_EX2IR = 4'h9, CPSC_TAP_UPDIR = 4'h8
  } cpsc_tap_t;

  typedef struct packed {
    logic       select_a_n;
    logic       select_b_n;
    logic       write_strobe_n;
    logic [7:0] data;
    logic       serial_in;
  } cpsc_cfg_pins_t;

  typedef struct packed {
    logic fabric_run;
    logic fabric_clear;
    logic io_tristate;
    logic user_io_mode;
  } cpsc_fabric_ctl_t;
endpackage

//--- dv/cpsc_host_model.sv
`timescale 1ns/10ps
module cpsc_host_model import cpsc_pkg::*; (
  // Link clock and configuration pins
  output logic           config_clock_o,
  output cpsc_cfg_pins_t cfg_pins_o
);
  initial begin
    config_clock_o = 1'b0;
    cfg_pins_o     = '1;
    // Settle the link-domain registers while loading is off
    repeat (3) tick();
  end

  // One link period, clock stops low
  task automatic tick;
    #32 config_clock_o = 1'b1;
    #32 config_clock_o = 1'b0;
  endtask

  // Idle edges, one unit per rising edge, then pins back to pull-up level
  task automatic send(input logic par, input int unsigned units);
    #7;
    repeat (3) tick();
    for (int unsigned i = 0; i < units; i++) begin
      cfg_pins_o.select_a_n     = ~par;
      cfg_pins_o.select_b_n     = ~par;
      cfg_pins_o.write_strobe_n = ~par;
      cfg_pins_o.data           = 8'(i * 37);
      cfg_pins_o.serial_in      = i[0] ^ i[2];
      tick();
    end
    cfg_pins_o = '1;
    // Let the load-off crossing clear the link done level
    repeat (4) tick();
  endtask
endmodule

//--- dv/tb.sv
`timescale 1ns/10ps
`include "cpsc_params.svh"
module tb import cpsc_pkg::*; ;
  localparam int unsigned DL    = 40;
  localparam int unsigned DLMAX = 60;
  logic             ref_clk, rst, prog_n, sleep_n, toe_n, link_clk, prev_si;
  logic             init_oe, init_o, init_wire, done_oe, done_o, so, so_oe;
  logic             tck, tms, tdi, tdo, tdo_oe, init_hold;
  logic [1:0]       mode;
  cpsc_cfg_pins_t   pins;
  cpsc_fabric_ctl_t fab;
  cpsc_port_t       port;
  int               bad_count, comparisons;

  // Open-drain init wire with pull-up
  assign init_wire = init_oe ? init_o : ~init_hold;

  cpsc_top #(.DL_CYCLES(DL), .DL_MAX_CYCLES(DLMAX)) u_dut (
    .ref_clk_i(ref_clk), .reset_i(rst), .ce_i(1'b1),
    .program_request_n_i(prog_n), .sleep_request_n_i(sleep_n),
    .io_output_enable_n_i(toe_n), .config_mode_i(mode),
    .init_ready_n_i(init_wire), .init_ready_n_o(init_o), .init_ready_n_oe_o(init_oe),
    .done_o(done_o), .done_oe_o(done_oe),
    .config_clock_i(link_clk), .cfg_pins_i(pins),
    .serial_out_o(so), .serial_out_oe_o(so_oe),
    .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
    .fabric_ctl_o(fab), .config_port_o(port)
  );

  cpsc_host_model u_host (.config_clock_o(link_clk), .cfg_pins_o(pins));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run;
    if (bad_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic do_reset;
    @(negedge ref_clk);
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
  endtask

  task automatic start_cfg(input logic [1:0] m);
    @(negedge ref_clk);
    mode   = m;
    prog_n = 1'b0;
    cyc(4);
    prog_n = 1'b1;
  endtask

  task automatic wait_done(output int n);
    n = 0;
    while (done_oe !== 1'b0 && n < 500) begin
      cyc(1);
      n++;
    end
  endtask

  // Serial out copies the bit taken at the same rising edge
  always @(posedge link_clk) begin
    prev_si = pins.serial_in;
    #1;
    if (so_oe === 1'b1 && mode === 2'h0) check("serial_out", {7'h00, so}, {7'h00, prev_si});
  end

  task automatic t_reset;
    check("init_oe", 8'(init_oe), 8'h01);
    check("done_oe", 8'(done_oe), 8'h01);
    check("fabric", 8'(fab), 8'h06);
    check("port", 8'(port), 8'(CPSC_PORT_NONE));
  endtask

  task automatic t_link(input logic par);
    int n;
    start_cfg({1'b0, par});
    cyc(40);
    check("port", 8'(port), 8'(CPSC_PORT_SYSCFG));
    check("done_early", 8'(done_oe), 8'h01);
    u_host.send(par, par ? 8 : 64);
    wait_done(n);
    check("done_oe", 8'(done_oe), 8'h00);
    check("user_io", 8'(fab.user_io_mode), 8'h01);
  endtask

  task automatic t_toe;
    toe_n = 1'b0;
    cyc(4);
    check("toe_tri", 8'(fab.io_tristate), 8'h01);
    toe_n = 1'b1;
    cyc(4);
    check("toe_free", 8'(fab.io_tristate), 8'h00);
    prog_n = 1'b0;
    cyc(4);
    check("reclear_done", 8'(done_oe), 8'h01);
    check("reclear_fab", 8'(fab.fabric_clear), 8'h01);
    prog_n = 1'b1;
  endtask

  task automatic t_sleep;
    sleep_n = 1'b0;
    cyc(8);
    check("sleep_delay", 8'(fab.io_tristate), 8'h00);
    cyc(20);
    check("asleep", 8'({fab.fabric_run, fab.io_tristate}), 8'h01);
    sleep_n = 1'b1;
    cyc(10);
    check("wake_clear", 8'(fab.fabric_clear), 8'h01);
    check("wake_done", 8'(done_oe), 8'h01);
  endtask

  task automatic jclk(input logic ms, input logic di);
    tms = ms;
    tdi = di;
    cyc(4);
    tck = 1'b1;
    cyc(4);
    tck = 1'b0;
  endtask

  // Host holds init low so the test port can claim configuration
  task automatic t_jtag;
    logic [7:0] ir;
    ir        = `CPSC_IR_CFG_EN;
    init_hold = 1'b1;
    do_reset();
    cyc(30);
    jclk(1'b0, 1'b1);
    jclk(1'b1, 1'b1);
    jclk(1'b1, 1'b1);
    jclk(1'b0, 1'b1);
    jclk(1'b0, 1'b1);
    for (int i = 0; i < 8; i++) begin
      jclk(1'(i == 7), ir[i]);
    end
    jclk(1'b1, 1'b1);
    jclk(1'b0, 1'b1);
    cyc(4);
    check("jtag_port", 8'(port), 8'(CPSC_PORT_JTAG));
    check("jtag_busy", 8'(done_oe), 8'h01);
    jclk(1'b1, 1'b1);
    jclk(1'b0, 1'b1);
    jclk(1'b0, 1'b1);
    for (int i = 0; i < 64; i++) begin
      jclk(1'(i == 63), 1'b1);
      if (i == 8) begin
        check("tdo_oe", 8'(tdo_oe), 8'h01);
        check("tdo", 8'(tdo), 8'h01);
      end
    end
    cyc(6);
    check("jtag_done", 8'(done_oe), 8'h00);
    init_hold = 1'b0;
  endtask

  task automatic t_self;
    int n;
    start_cfg(2'h3);
    cyc(28);
    check("sdm_init", 8'(init_oe), 8'h01);
    wait_done(n);
    n = n + 28;
    check("dl_time", 8'(n >= DL && n <= DLMAX), 8'h01);
  endtask

  initial begin
    rst     = 1'b1;
    prog_n  = 1'b1;
    sleep_n = 1'b1;
    toe_n   = 1'b1;
    mode    = 2'h0;
    tck       = 1'b0;
    tms       = 1'b1;
    tdi       = 1'b1;
    init_hold = 1'b0;
    cyc(2);
    rst = 1'b0;
    cyc(1);
    t_reset();
    t_link(1'b0);
    t_toe();
    t_link(1'b1);
    // Sleep requested only outside configuration
    t_sleep();
    do_reset();
    t_self();
    t_jtag();
    complete_run();
  end

  initial begin
    #200000;
    bad_count++;
    complete_run();
  end
endmodule
